// ==== common/adc_pkg.sv ====
// types shared by the converter control block and its sequencer;
// assumes adc_regs.svh for the numeric constants.
package adc_pkg;

  typedef struct packed {
    logic conv_done_flag;
    logic conv_irq_enable;
    logic conv_start_bit;
    logic scan_mode;
    logic conv_period_select;
    logic [2:0] channel_sel;
  } csr_t;

  typedef enum {SEQ_IDLE, SEQ_RUN} seq_state_t;

endpackage

// ==== common/adc_regs.svh ====
// register indices, field positions, reset values and timing counts for the
// converter control block; assumes an AXI4-Lite slave with 32-bit data words.
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH

`define ADDR_W 18
`define IDX_RESULT_A 16'hffb0
`define IDX_CSR 16'hffb8
`define IDX_TRIG 16'hffb9
`define IDX_IRQ_STAT 16'hffc0
`define IDX_IRQ_CLR 16'hffc1
`define IDX_IRQ_EN 16'hffc2

`define CSR_FLAG 7
`define CSR_IE 6
`define CSR_START 5
`define CSR_SCAN 4
`define CSR_PERIOD 3
`define CSR_CH_HI 2
`define TRIG_EN 7
`define IRQ_DONE 0
`define IRQ_TRIG 1

`define CSR_RESET 8'h00
`define RESULT_RESET 16'h0000
`define RESULT_PAD 6'h00
`define IRQ_RESET 2'h0
`define CHAN_ZERO 3'h0

`define CONV_CYCLES_SLOW 134
`define CONV_CYCLES_FAST 70

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ==== dv/adc_core_model.sv ====
// analog core stand-in: returns a code for each sample strobe
// assumes the bench sets next_code before the start that uses it
`timescale 1ns/1ps

module adc_core_model (
  input wire logic aclk, // system clock
  input wire logic conv_start, // sample strobe from the block
  input wire logic [9:0] next_code, // code for the coming conversion
  output logic [9:0] core_data // code held until the next strobe
);
  // the code is latched on the strobe, so a late bench update cannot leak in
  always_ff @(posedge aclk) begin
    if (conv_start) begin
      core_data <= next_code;
    end
  end
endmodule

// ==== dv/tb.sv ====
// self-checking bench for the converter control block
// assumes register layout and timing of adc_regs.svh, one clock domain
`timescale 1ns/1ps
`include "adc_regs.svh"

module tb import adc_pkg::*;;
  localparam logic [17:0] A_RES = {`IDX_RESULT_A, 2'b00};
  localparam logic [17:0] A_CSR = {`IDX_CSR, 2'b00};
  localparam logic [17:0] A_TRG = {`IDX_TRIG, 2'b00};
  localparam logic [17:0] A_STAT = {`IDX_IRQ_STAT, 2'b00};
  localparam logic [17:0] A_CLR = {`IDX_IRQ_CLR, 2'b00};
  localparam logic [17:0] A_EN = {`IDX_IRQ_EN, 2'b00};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [17:0] awaddr = '0;
  logic [17:0] araddr = '0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic ext_trigger_pin = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = '0;
  logic [9:0] next_code = '0;
  logic [9:0] core_data;
  logic awready, wready, bvalid, arready, rvalid, conv_start, conv_period_select, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] conv_channel;
  logic irq_q = 1'b0;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int st = 0;
  int lat = 0;
  int n_start = 0;

  always #4 aclk = ~aclk;

  adc_conversion_control i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .ext_trigger_pin, .core_data, .conv_start, .conv_channel,
    .conv_period_select, .irq);
  adc_core_model i_core (.aclk, .conv_start, .next_code, .core_data);

  // start-to-interrupt latency, counted in whole clock cycles
  always @(posedge aclk) begin
    cyc++;
    if (conv_start === 1'b1) begin
      st = cyc;
      n_start++;
    end
    if (irq === 1'b1 && irq_q !== 1'b1) lat = cyc - st;
    irq_q = irq;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    repeat (300) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    chk({30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [17:0] a, input logic [31:0] ex, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    repeat (300) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    chk(rdata, ex);
    chk({30'h0, rresp}, {30'h0, er});
    rready <= 1'b0;
  endtask

  task automatic run_conv(input logic [7:0] csr, input logic [9:0] code, input int el);
    next_code <= code;
    lat = 0;
    wr(A_CSR, {24'h0, csr}, `RESP_OKAY);
    repeat (300) begin
      @(posedge aclk);
      if (lat != 0) break;
    end
    chk(lat, el);
  endtask

  task automatic trig_pulse();
    @(posedge aclk);
    ext_trigger_pin <= 1'b1;
    repeat (2) @(posedge aclk);
    ext_trigger_pin <= 1'b0;
    repeat (10) @(posedge aclk);
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    print_verdict();
  end

  initial begin
    logic [17:0] regs[6];
    int n_before;
    regs = '{A_RES, A_CSR, A_TRG, A_STAT, A_CLR, A_EN};
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (regs[i]) rd(regs[i], 32'h0, `RESP_OKAY);
    rd(18'h00010, 32'h0, `RESP_SLVERR);
    wr(18'h00010, 32'hff, `RESP_SLVERR);
    wr(A_RES, 32'hffff, `RESP_OKAY);
    rd(A_RES, 32'h0, `RESP_OKAY);
    $display("test registers done");
    // single channel-zero conversion, interrupt disabled
    next_code <= 10'h2a5;
    wr(A_CSR, 32'h20, `RESP_OKAY);
    repeat (140) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    wr(A_CSR, 32'h00, `RESP_OKAY);
    rd(A_CSR, 32'h80, `RESP_OKAY);
    wr(A_CSR, 32'h00, `RESP_OKAY);
    rd(A_CSR, 32'h00, `RESP_OKAY);
    rd(A_RES, 32'ha940, `RESP_OKAY);
    $display("test single done");
    // short period, channel three: result of channel zero must stay
    run_conv(8'h6b, 10'h155, 71);
    chk({28'h0, conv_period_select, conv_channel}, 32'hb);
    repeat (20) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    rd(A_RES, 32'ha940, `RESP_OKAY);
    rd(A_CSR, 32'hcb, `RESP_OKAY);
    wr(A_CSR, 32'h40, `RESP_OKAY);
    wr(A_CLR, 32'h1, `RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    run_conv(8'h60, 10'h3c3, 135);
    chk({29'h0, conv_channel}, 32'h0);
    rd(A_RES, 32'hf0c0, `RESP_OKAY);
    rd(A_CSR, 32'hc0, `RESP_OKAY);
    wr(A_CSR, 32'h00, `RESP_OKAY);
    wr(A_CLR, 32'h1, `RESP_OKAY);
    $display("test interrupt enable done");
    // status register path: raise, mask, clear
    wr(A_EN, 32'h1, `RESP_OKAY);
    rd(A_EN, 32'h1, `RESP_OKAY);
    wr(A_CSR, 32'h20, `RESP_OKAY);
    repeat (140) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    rd(A_STAT, 32'h1, `RESP_OKAY);
    wr(A_EN, 32'h0, `RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    wr(A_EN, 32'h1, `RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    wr(A_CLR, 32'h1, `RESP_OKAY);
    rd(A_STAT, 32'h0, `RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    rd(A_CSR, 32'h80, `RESP_OKAY);
    wr(A_CSR, 32'h00, `RESP_OKAY);
    wr(A_EN, 32'h0, `RESP_OKAY);
    $display("test status path done");
    // scan mode: back-to-back conversions until start is written low
    n_before = n_start;
    wr(A_CSR, 32'h38, `RESP_OKAY);
    repeat (150) @(posedge aclk);
    wr(A_CSR, 32'h18, `RESP_OKAY);
    repeat (150) @(posedge aclk);
    chk(n_start, n_before + 3);
    rd(A_CSR, 32'h98, `RESP_OKAY);
    wr(A_CSR, 32'h00, `RESP_OKAY);
    wr(A_CLR, 32'h1, `RESP_OKAY);
    $display("test scan done");
    // trigger ignored while disabled, honoured once enabled
    n_before = n_start;
    trig_pulse();
    chk(n_start, n_before);
    wr(A_TRG, 32'h80, `RESP_OKAY);
    rd(A_TRG, 32'h80, `RESP_OKAY);
    trig_pulse();
    chk(n_start, n_before + 1);
    repeat (140) @(posedge aclk);
    rd(A_STAT, 32'h3, `RESP_OKAY);
    rd(A_CLR, 32'h0, `RESP_OKAY);
    $display("test trigger done");
    print_verdict();
  end
endmodule

// ==== hdl/adc_conv_seq.sv ====
// conversion period sequencer: times one conversion from a start pulse;
// assumes the analog core holds its code valid when done is raised.
`timescale 1ns/1ps
`include "adc_regs.svh"

module adc_conv_seq
  import adc_pkg::*;
(
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic go, // one-cycle start pulse, only while idle
  input wire logic period_select, // long or short period
  output logic done // one-cycle pulse, conversion over
);

  // start pulse, done register and flag register each add one edge to the count
  localparam logic [7:0] LOAD_SLOW = 8'(`CONV_CYCLES_SLOW - 3);
  localparam logic [7:0] LOAD_FAST = 8'(`CONV_CYCLES_FAST - 3);
  localparam int CONV_MAX = `CONV_CYCLES_SLOW;

  seq_state_t state_r;
  logic [7:0] cnt_r;
  logic done_r;

  wire logic cnt_end = (state_r == SEQ_RUN) && (cnt_r == 8'h00);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= SEQ_IDLE;
      cnt_r <= 8'h00;
      done_r <= 1'b0;
    end else begin
      done_r <= cnt_end;
      case (state_r)
        SEQ_IDLE: begin
          if (go) begin
            state_r <= SEQ_RUN;
            cnt_r <= period_select ? LOAD_FAST : LOAD_SLOW;
          end
        end
        SEQ_RUN: begin
          if (cnt_end) begin
            state_r <= SEQ_IDLE;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        default: state_r <= SEQ_IDLE;
      endcase
    end
  end

  assign done = done_r;

  conv_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (go && !period_select && state_r == SEQ_IDLE) |-> ##[1:CONV_MAX] done_r)
    else $error("conversion overran its period");

  conv_early_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (go && state_r == SEQ_IDLE) |=> !done_r [*8])
    else $error("conversion ended too early");

endmodule

// ==== hdl/adc_conversion_control.sv ====
// converter control: control/status, trigger control and result registers
// behind an AXI4-Lite slave, plus start, trigger and interrupt logic.
// assumes one-word aligned accesses and an analog core with a 10-bit code.
`timescale 1ns/1ps
`include "adc_regs.svh"

module adc_conversion_control
  import adc_pkg::*;
(
  input wire logic aclk, // system clock, 125 MHz
  input wire logic aresetn, // sync reset, active low
  input wire logic [`ADDR_W-1:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [`ADDR_W-1:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic ext_trigger_pin, // external start trigger
  input wire logic [9:0] core_data, // conversion code from analog core
  output logic conv_start, // one-cycle sample pulse to core
  output logic [2:0] conv_channel, // channel held for the core
  output logic conv_period_select, // period held for the core
  output logic irq // level interrupt
);

  csr_t csr_r, csr_nxt;
  logic ext_trigger_enable_r;
  logic [15:0] result_r;
  logic [1:0] irq_stat_r, irq_stat_nxt, irq_en_r;
  logic arm_r, busy_r, go_r, trig_d_r, irq_r;
  logic [2:0] chan_r;
  logic period_r;
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic [`ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic seq_done;

  function automatic logic hit(input logic [`ADDR_W-1:0] addr, input logic [15:0] idx);
    hit = (addr[`ADDR_W-1:2] == idx);
  endfunction

  function automatic logic known(input logic [`ADDR_W-1:0] addr);
    known = hit(addr, `IDX_RESULT_A) | hit(addr, `IDX_CSR) | hit(addr, `IDX_TRIG)
          | hit(addr, `IDX_IRQ_STAT) | hit(addr, `IDX_IRQ_CLR) | hit(addr, `IDX_IRQ_EN);
  endfunction

  // write path: address and data may arrive in either order
  wire logic aw_take = awvalid & awready_r;
  wire logic w_take = wvalid & wready_r;
  wire logic wr_fire = ~awready_r & ~wready_r & ~bvalid_r;
  wire logic wr_lane0 = wr_fire & wstrb_r[0];
  wire logic wr_csr = wr_lane0 & hit(awaddr_r, `IDX_CSR);
  wire logic wr_trig = wr_lane0 & hit(awaddr_r, `IDX_TRIG);
  wire logic wr_iclr = wr_lane0 & hit(awaddr_r, `IDX_IRQ_CLR);
  wire logic wr_ien = wr_lane0 & hit(awaddr_r, `IDX_IRQ_EN);
  wire logic wr_known = known(awaddr_r);

  // read path
  wire logic rd_take = arvalid & arready_r;
  wire logic rd_known = known(araddr);
  wire logic [31:0] rd_word =
      hit(araddr, `IDX_RESULT_A) ? {16'h0000, result_r} :
      hit(araddr, `IDX_CSR) ? {24'h000000, csr_r} :
      hit(araddr, `IDX_TRIG) ? {24'h000000, ext_trigger_enable_r, 7'h00} :
      hit(araddr, `IDX_IRQ_STAT) ? {30'h00000000, irq_stat_r} :
      hit(araddr, `IDX_IRQ_EN) ? {30'h00000000, irq_en_r} : 32'h00000000;
  // arming on the read itself keeps a stale read from enabling a later clear
  wire logic rd_flag_one = rd_take & hit(araddr, `IDX_CSR) & csr_r.conv_done_flag;

  // start sources
  wire logic trig_edge = ext_trigger_pin & ~trig_d_r;
  wire logic trig_go = trig_edge & ext_trigger_enable_r & ~busy_r;
  wire logic sw_go = wr_csr & wdata_r[`CSR_START] & ~busy_r;
  wire logic scan_go = seq_done & csr_r.scan_mode & csr_r.conv_start_bit;
  wire logic go_nxt = sw_go | trig_go | scan_go;
  wire logic single_done = seq_done & ~csr_r.scan_mode;
  wire logic flag_clear = wr_csr & ~wdata_r[`CSR_FLAG] & arm_r;
  wire logic irq_nxt = (csr_r.conv_done_flag & csr_r.conv_irq_enable)
                     | (|(irq_stat_r & irq_en_r));

  always_comb begin
    csr_nxt = csr_r;
    if (wr_csr) begin
      csr_nxt.conv_irq_enable = wdata_r[`CSR_IE];
      csr_nxt.scan_mode = wdata_r[`CSR_SCAN];
      csr_nxt.conv_period_select = wdata_r[`CSR_PERIOD];
      csr_nxt.channel_sel = wdata_r[`CSR_CH_HI:0];
      if (flag_clear) begin
        csr_nxt.conv_done_flag = 1'b0;
      end
      if (wdata_r[`CSR_START]) begin
        csr_nxt.conv_start_bit = 1'b1;
      end else if (csr_r.scan_mode) begin
        csr_nxt.conv_start_bit = 1'b0;
      end
    end
    if (trig_go) begin
      csr_nxt.conv_start_bit = 1'b1;
    end
    // set wins over a clear landing in the same cycle
    if (seq_done) begin
      csr_nxt.conv_done_flag = 1'b1;
    end
    if (single_done) begin
      csr_nxt.conv_start_bit = 1'b0;
    end
  end

  always_comb begin
    irq_stat_nxt = irq_stat_r & ~(wr_iclr ? wdata_r[1:0] : `IRQ_RESET);
    irq_stat_nxt[`IRQ_DONE] = irq_stat_nxt[`IRQ_DONE] | seq_done;
    irq_stat_nxt[`IRQ_TRIG] = irq_stat_nxt[`IRQ_TRIG] | trig_go;
  end

  // bus handshakes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end else begin
      if (aw_take) begin
        awready_r <= 1'b0;
      end else if (wr_fire) begin
        awready_r <= 1'b1;
      end
      if (w_take) begin
        wready_r <= 1'b0;
      end else if (wr_fire) begin
        wready_r <= 1'b1;
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (aw_take) begin
      awaddr_r <= awaddr;
    end
    if (w_take) begin
      wdata_r <= wdata;
      wstrb_r <= wstrb;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `RESP_OKAY;
    end else if (rd_take) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_r && rready) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
    end
  end

  // registers and control
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      csr_r <= `CSR_RESET;
      ext_trigger_enable_r <= 1'b0;
      irq_stat_r <= `IRQ_RESET;
      irq_en_r <= `IRQ_RESET;
      arm_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      csr_r <= csr_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_r <= irq_nxt;
      if (wr_trig) begin
        ext_trigger_enable_r <= wdata_r[`TRIG_EN];
      end
      if (wr_ien) begin
        irq_en_r <= wdata_r[1:0];
      end
      // any control/status write uses up the arming, unless a flag read arms it in the same cycle
      if (rd_flag_one) begin
        arm_r <= 1'b1;
      end else if (wr_csr) begin
        arm_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_r <= 1'b0;
      go_r <= 1'b0;
      trig_d_r <= 1'b0;
      chan_r <= `CHAN_ZERO;
      period_r <= 1'b0;
      result_r <= `RESULT_RESET;
    end else begin
      busy_r <= go_nxt | (busy_r & ~seq_done);
      go_r <= go_nxt;
      trig_d_r <= ext_trigger_pin;
      if (go_nxt) begin
        chan_r <= csr_nxt.channel_sel;
        period_r <= csr_nxt.conv_period_select;
      end
      // captured on the same edge that sets the flag
      if (seq_done && chan_r == `CHAN_ZERO) begin
        result_r <= {core_data, `RESULT_PAD};
      end
    end
  end

  adc_conv_seq u_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .go(go_r),
    .period_select(period_r),
    .done(seq_done)
  );

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign conv_start = go_r;
  assign conv_channel = chan_r;
  assign conv_period_select = period_r;
  assign irq = irq_r;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  flag_set_a: assert property (seq_done |=> csr_r.conv_done_flag)
    else $error("done flag not set after conversion");

  flag_hold_a: assert property (
    (csr_r.conv_done_flag && !(wr_csr && arm_r && !wdata_r[`CSR_FLAG]))
    |=> csr_r.conv_done_flag)
    else $error("done flag cleared without read then write");

  irq_gate_a: assert property (
    (!csr_r.conv_irq_enable && (irq_stat_r & irq_en_r) == `IRQ_RESET) |=> !irq_r)
    else $error("interrupt raised while disabled");

  start_conv_a: assert property (sw_go |=> conv_start ##1 busy_r)
    else $error("start write did not begin conversion");

  start_clear_a: assert property (single_done |=> !csr_r.conv_start_bit)
    else $error("start bit stayed set after single conversion");

  single_once_a: assert property (single_done |=> !go_r)
    else $error("single mode restarted by itself");

  chan_sel_a: assert property (sw_go |=> conv_channel == $past(wdata_r[`CSR_CH_HI:0]))
    else $error("channel not taken from select bits");

  trig_block_a: assert property (
    (trig_edge && !ext_trigger_enable_r && !sw_go && !scan_go) |=> !conv_start)
    else $error("trigger started conversion while disabled");

  result_a: assert property (
    (seq_done && chan_r == `CHAN_ZERO) |=>
      (result_r == {$past(core_data), `RESULT_PAD}) && csr_r.conv_done_flag)
    else $error("channel zero result not stored with flag");

  irq_level_a: assert property (
    (csr_r.conv_done_flag && csr_r.conv_irq_enable) |=> irq_r)
    else $error("interrupt missing while flag set and enabled");

endmodule
